// [hdl/eeac_top.sv]
// Data EEPROM access controller: address, data and control registers,
// bank-gated control access, read and timed write cycles, interrupts.
// Assumes a single-cycle register port master on core_clk.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module eeac_top
  import eeac_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Core interrupt handshake
  input wire logic stackFull,
  input wire logic intService,
  output logic intVectorReq,
  output logic irq
);

  // Register port request and cycle state
  eeac_req_t req;
  eeac_state_t stateQ;
  eeac_mem_t memCmd;

  // Software-visible registers
  logic [EE_AW-1:0] eepromAddrQ;
  logic [7:0] eepromDataQ;
  logic [3:0] eepromCtrlQ;
  logic [7:0] bankSelQ;
  logic [7:0] indirPtrQ;
  logic [1:0] irqStatQ;
  logic [1:0] irqMaskQ;

  // Multi-function interrupt enables and request flags
  logic globalEnQ;
  logic groupEnQ;
  logic eepromIrqEnQ;
  logic eepromIrqFlagQ;
  logic groupFlagQ;

  // Address, data and read count held for the running cycle
  logic [EE_AW-1:0] latAddrQ;
  logic [7:0] latDataQ;
  logic [3:0] rdCntQ;

  // Returns from the cell array and the write timer
  logic [7:0] arrRd;
  logic wrDone;

  // Control register access decode
  logic ctrlVisible;
  logic ctrlWr;
  logic [3:0] ctrlWval;

  // Cycle start and end events
  logic wrStart;
  logic rdStart;
  logic rdEnd;
  logic cycEnd;

  assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};

  // Control register is visible only in bank 1, directly or indirectly
  assign ctrlVisible = (bankSelQ == CTRL_BANK);
  assign ctrlWr = req.wr && ctrlVisible && (req.addr == CTRL_REG_OFS ||
    (req.addr == INDIR_PORT_OFS && indirPtrQ == CTRL_INDIR_ADDR));
  assign ctrlWval = req.wdata[3:0];

  // Start requests qualified by the enable already held
  assign rdStart = ctrlWr && stateQ == EEAC_IDLE && ctrlWval[CTRL_RD_POS] &&
    eepromCtrlQ[CTRL_READ_ENABLE_BIT_POS] && !eepromCtrlQ[CTRL_RD_POS];
  assign wrStart = ctrlWr && stateQ == EEAC_IDLE && ctrlWval[CTRL_WR_POS] &&
    eepromCtrlQ[CTRL_WRITE_ENABLE_BIT_POS] && !eepromCtrlQ[CTRL_WR_POS] &&
    !rdStart;
  assign rdEnd = stateQ == EEAC_READ && rdCntQ == 4'(READ_CYCLES);
  assign cycEnd = rdEnd || wrDone;

  // Array command uses values latched at cycle start
  assign memCmd = '{we: wrDone, addr: latAddrQ, data: latDataQ};

  eeac_array uArray (
    .core_clk(core_clk),
    .memCmd(memCmd),
    .rdData(arrRd)
  );

  eeac_wr_timer uTimer (
    .core_clk(core_clk),
    .rst(rst),
    .start(wrStart),
    .done(wrDone)
  );

  // Cycle sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateQ <= EEAC_IDLE;
      rdCntQ <= 4'h0;
    end else begin
      case (stateQ)
        EEAC_IDLE: begin
          rdCntQ <= 4'h0;
          if (rdStart) begin
            stateQ <= EEAC_READ;
          end else if (wrStart) begin
            stateQ <= EEAC_WRITE;
          end
        end
        EEAC_READ: begin
          rdCntQ <= rdCntQ + 4'h1;
          if (rdEnd) begin
            stateQ <= EEAC_IDLE;
          end
        end
        EEAC_WRITE: begin
          if (wrDone) begin
            stateQ <= EEAC_IDLE;
          end
        end
        default: stateQ <= EEAC_IDLE;
      endcase
    end
  end

  // Snapshot of address and data at cycle start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      latAddrQ <= '0;
      latDataQ <= 8'h00;
    end else if (rdStart || wrStart) begin
      latAddrQ <= eepromAddrQ;
      latDataQ <= eepromDataQ;
    end
  end

  // Control register: enables by software, start bits cleared by hardware
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eepromCtrlQ <= CTRL_RST;
    end else begin
      if (ctrlWr) begin
        eepromCtrlQ[CTRL_READ_ENABLE_BIT_POS] <= ctrlWval[CTRL_READ_ENABLE_BIT_POS];
        eepromCtrlQ[CTRL_WRITE_ENABLE_BIT_POS] <= ctrlWval[CTRL_WRITE_ENABLE_BIT_POS];
      end
      if (rdStart) begin
        eepromCtrlQ[CTRL_RD_POS] <= 1'b1;
      end else if (rdEnd) begin
        eepromCtrlQ[CTRL_RD_POS] <= 1'b0;
      end
      if (wrStart) begin
        eepromCtrlQ[CTRL_WR_POS] <= 1'b1;
      end else if (wrDone) begin
        eepromCtrlQ[CTRL_WR_POS] <= 1'b0;
      end
    end
  end

  // Address register, six bits
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eepromAddrQ <= '0;
    end else if (req.wr && req.addr == ADDR_REG_OFS) begin
      eepromAddrQ <= req.wdata[EE_AW-1:0];
    end
  end

  // Data register: software write, or read result at read end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eepromDataQ <= 8'h00;
    end else if (rdEnd) begin
      eepromDataQ <= arrRd;
    end else if (req.wr && req.addr == DATA_REG_OFS) begin
      eepromDataQ <= req.wdata;
    end
  end

  // Bank selector and indirect pointer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bankSelQ <= BANK_RST;
      indirPtrQ <= PTR_RST;
    end else begin
      if (req.wr && req.addr == BANK_REG_OFS) begin
        bankSelQ <= req.wdata;
      end
      if (req.wr && req.addr == INDIR_PTR_OFS) begin
        indirPtrQ <= req.wdata;
      end
    end
  end

  // Sticky done status, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqStatQ <= 2'h0;
      irqMaskQ <= IRQ_MASK_RST;
    end else begin
      if (req.wr && req.addr == IRQ_MASK_OFS) begin
        irqMaskQ <= req.wdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if ((i == IRQ_RDDONE_POS && rdEnd) || (i == IRQ_WRDONE_POS && wrDone)) begin
          irqStatQ[i] <= 1'b1;
        end else if (req.wr && req.addr == IRQ_STAT_OFS && req.wdata[i]) begin
          irqStatQ[i] <= 1'b0;
        end
      end
    end
  end

  // Multi-function enables and flags
  always_ff @(posedge core_clk) begin
    if (rst) begin
      globalEnQ <= 1'b0;
      groupEnQ <= 1'b0;
      eepromIrqEnQ <= 1'b0;
      eepromIrqFlagQ <= 1'b0;
      groupFlagQ <= 1'b0;
    end else begin
      if (req.wr && req.addr == MF_CTRL_OFS) begin
        globalEnQ <= req.wdata[MF_GLOBAL_EN_POS];
        groupEnQ <= req.wdata[MF_GROUP_EN_POS];
        eepromIrqEnQ <= req.wdata[MF_EE_EN_POS];
      end
      if (cycEnd) begin
        eepromIrqFlagQ <= 1'b1;
      end else if (req.wr && req.addr == MF_CTRL_OFS && !req.wdata[MF_EE_FLAG_POS]) begin
        eepromIrqFlagQ <= 1'b0;
      end
      if (cycEnd) begin
        groupFlagQ <= 1'b1;
      end else if (intService || (req.wr && req.addr == MF_CTRL_OFS &&
          !req.wdata[MF_GROUP_FLAG_POS])) begin
        groupFlagQ <= 1'b0;
      end
    end
  end

  // Interrupt outputs from flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
      intVectorReq <= 1'b0;
    end else begin
      irq <= |(irqStatQ & irqMaskQ);
      intVectorReq <= globalEnQ && groupEnQ && eepromIrqEnQ && eepromIrqFlagQ &&
        groupFlagQ && !stackFull && !intService;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_REG_OFS: regRdata <= {2'b00, eepromAddrQ};
        DATA_REG_OFS: regRdata <= eepromDataQ;
        CTRL_REG_OFS: regRdata <= ctrlVisible ? {4'h0, eepromCtrlQ} : 8'h00;
        BANK_REG_OFS: regRdata <= bankSelQ;
        IRQ_STAT_OFS: regRdata <= {6'h00, irqStatQ};
        IRQ_MASK_OFS: regRdata <= {6'h00, irqMaskQ};
        MF_CTRL_OFS: regRdata <= {3'h0, eepromIrqFlagQ, groupFlagQ, eepromIrqEnQ,
          groupEnQ, globalEnQ};
        INDIR_PTR_OFS: regRdata <= indirPtrQ;
        INDIR_PORT_OFS: regRdata <= (ctrlVisible && indirPtrQ == CTRL_INDIR_ADDR) ?
          {4'h0, eepromCtrlQ} : 8'h00;
        CORE_STAT_OFS: regRdata <= {6'h00, stateQ};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// [hdl/eeac_pkg.sv]
// Package for the data EEPROM access controller: register offsets, field
// positions, reset values, timing counts, states and carrier structs.
// Assumes one 125 MHz core clock and a plain register port.
`default_nettype none
package eeac_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_REG_OFS = 8'h00;
  localparam logic [7:0] DATA_REG_OFS = 8'h01;
  localparam logic [7:0] CTRL_REG_OFS = 8'h02;
  localparam logic [7:0] BANK_REG_OFS = 8'h03;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h05;
  localparam logic [7:0] MF_CTRL_OFS = 8'h06;
  localparam logic [7:0] INDIR_PTR_OFS = 8'h07;
  localparam logic [7:0] INDIR_PORT_OFS = 8'h08;
  localparam logic [7:0] CORE_STAT_OFS = 8'h09;

  // Control register field positions
  localparam int CTRL_RD_POS = 0;
  localparam int CTRL_READ_ENABLE_BIT_POS = 1;
  localparam int CTRL_WR_POS = 2;
  localparam int CTRL_WRITE_ENABLE_BIT_POS = 3;

  // Interrupt status / mask bit positions
  localparam int IRQ_RDDONE_POS = 0;
  localparam int IRQ_WRDONE_POS = 1;

  // Multi-function control bit positions
  localparam int MF_GLOBAL_EN_POS = 0;
  localparam int MF_GROUP_EN_POS = 1;
  localparam int MF_EE_EN_POS = 2;
  localparam int MF_GROUP_FLAG_POS = 3;
  localparam int MF_EE_FLAG_POS = 4;

  // Bank holding the control register and its indirect address
  localparam logic [7:0] CTRL_BANK = 8'h01;
  localparam logic [7:0] CTRL_INDIR_ADDR = 8'h40;

  // Reset values
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [7:0] PTR_RST = 8'h00;

  // Array geometry
  localparam int EE_AW = 6;
  localparam int EE_DEPTH = 64;

  // Timing: read access time and a free-running write timer
  localparam int CLK_PERIOD_NS = 8;
  localparam int READ_TIME_NS = 40;
  localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_TICK_DIV = 37;
  localparam int WR_TICKS = 16;

  typedef enum logic [1:0] {
    EEAC_IDLE = 2'b00,
    EEAC_READ = 2'b01,
    EEAC_WRITE = 2'b10
  } eeac_state_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eeac_req_t;

  // Array access command
  typedef struct packed {
    logic we;
    logic [EE_AW-1:0] addr;
    logic [7:0] data;
  } eeac_mem_t;

endpackage
`default_nettype wire

// [hdl/eeac_array.sv]
// Data EEPROM cell array, 64 bytes, synchronous read and write.
// Assumes the controller holds address and data stable during an access.
`timescale 1ns/1ps
`default_nettype none
module eeac_array
  import eeac_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Access
  input wire eeac_mem_t memCmd,
  output logic [7:0] rdData
);

  logic [7:0] cells [EE_DEPTH];

  // Store on write, fetch every cycle
  always_ff @(posedge core_clk) begin
    if (memCmd.we) begin
      cells[memCmd.addr] <= memCmd.data;
    end
    rdData <= cells[memCmd.addr];
  end

endmodule
`default_nettype wire

// [hdl/eeac_wr_timer.sv]
// Write-cycle timer, an independent tick source that is not phase-locked to
// the software view of the clock; a write ends on a tick count.
// Assumes start is a one-cycle pulse from the controller.
`timescale 1ns/1ps
`default_nettype none
module eeac_wr_timer
  import eeac_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic done
);

  logic [7:0] divQ;
  logic [4:0] tickQ;
  logic runQ;

  // Free-running divider, never reset by a start, so latency varies
  always_ff @(posedge core_clk) begin
    if (rst) begin
      divQ <= 8'h00;
    end else if (divQ == 8'(WR_TICK_DIV - 1)) begin
      divQ <= 8'h00;
    end else begin
      divQ <= divQ + 8'h01;
    end
  end

  // Tick counter for one write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      runQ <= 1'b0;
      tickQ <= 5'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        runQ <= 1'b1;
        tickQ <= 5'h00;
      end else if (runQ && divQ == 8'h00) begin
        if (tickQ == 5'(WR_TICKS - 1)) begin
          runQ <= 1'b0;
          done <= 1'b1;
        end
        tickQ <= tickQ + 5'h01;
      end
    end
  end

endmodule
`default_nettype wire

// [tb/eeac_chk.sv]
// Port checker for the EEPROM access controller.
// Assumes binding into eeac_top, one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module eeac_chk
  import eeac_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // Core handshake
  input wire logic stackFull,
  input wire logic intService,
  input wire logic intVectorReq,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] bank_q;
  logic [1:0] mask_q;
  logic [2:0] mf_q;
  // Shadows of software-owned settings
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bank_q <= BANK_RST;
      mask_q <= IRQ_MASK_RST;
      mf_q <= 3'h0;
    end else if (regWr) begin
      if (regAddr == BANK_REG_OFS) bank_q <= regWdata;
      if (regAddr == IRQ_MASK_OFS) mask_q <= regWdata[1:0];
      if (regAddr == MF_CTRL_OFS) mf_q <= regWdata[2:0];
    end
  end
  property p_bank;
    regRd && regAddr == CTRL_REG_OFS && bank_q != CTRL_BANK |=> regRdata == 8'h00;
  endproperty
  a_bank: assert property (p_bank) else $error("ctrl seen off bank");
  property p_ctlHi;
    regRd && regAddr == CTRL_REG_OFS |=> regRdata[7:4] == 4'h0;
  endproperty
  a_ctlHi: assert property (p_ctlHi) else $error("ctrl upper bits");
  property p_adrHi;
    regRd && regAddr == ADDR_REG_OFS |=> regRdata[7:6] == 2'h0;
  endproperty
  a_adrHi: assert property (p_adrHi) else $error("addr upper bits");
  property p_stk; stackFull |=> !intVectorReq; endproperty
  a_stk: assert property (p_stk) else $error("vector with full stack");
  property p_svc; intService |=> !intVectorReq; endproperty
  a_svc: assert property (p_svc) else $error("vector after service");
  property p_vec;
    intVectorReq |-> $past(mf_q) == 3'h7 && !$past(stackFull);
  endproperty
  a_vec: assert property (p_vec) else $error("vector not enabled");
  property p_irq; irq |-> $past(mask_q) != 2'h0; endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
  property p_irqOff;
    regWr && regAddr == IRQ_MASK_OFS && regWdata[1:0] == 2'h0 |=> ##1 !irq;
  endproperty
  a_irqOff: assert property (p_irqOff) else $error("irq after mask off");
  // Main scenarios reached
  c_irq: cover property (irq);
  c_vec: cover property (intVectorReq);
  c_ctl: cover property (regRd && regAddr == CTRL_REG_OFS && bank_q == CTRL_BANK);
endmodule
bind eeac_top eeac_chk u_chk (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .stackFull(stackFull), .intService(intService), .intVectorReq(intVectorReq), .irq(irq));
`default_nettype wire

// [tb/eeac_core_model.sv]
// Core model: answers the group vector with a service pulse.
// Assumes one core clock; stack fullness is set by the bench.
`timescale 1ns/1ps
`default_nettype none
module eeac_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bench control
  input wire logic fullCmd,
  input wire logic [3:0] lat,
  // Core handshake
  input wire logic intVectorReq,
  output logic stackFull,
  output logic intService
);
  logic [3:0] cnt_q;
  // Full stack holds off the vector
  assign stackFull = fullCmd;
  // Vector taken after a latency, then one service pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
      intService <= 1'b0;
    end else begin
      intService <= 1'b0;
      if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
        intService <= (cnt_q == 4'h1);
      end else if (intVectorReq && !intService) begin
        cnt_q <= lat + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/test_data_eeprom_access_control.sv]
// Testbench for the EEPROM access controller.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module test_data_eeprom_access_control;
  import eeac_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic fullCmd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [7:0] rdv;
  logic stackFull, intService, intVectorReq, irq;
  int error_cnt = 0;
  int n_tests = 0;
  // Clock at 125 MHz
  initial forever #4 core_clk = ~core_clk;
  eeac_top DUT (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .stackFull(stackFull),
    .intService(intService), .intVectorReq(intVectorReq), .irq(irq));
  eeac_core_model u_core (.core_clk(core_clk), .rst(rst), .fullCmd(fullCmd), .lat(4'h3),
    .intVectorReq(intVectorReq), .stackFull(stackFull), .intService(intService));
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    rdv = regRdata;
  endtask
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Poll a control bit until hardware clears it
  task automatic wt(input int b);
    int i;
    i = 0;
    rdv = 8'hff;
    while (rdv[b] !== 1'b0 && i < 900) begin
      rd(CTRL_REG_OFS);
      i++;
    end
    ck({7'h0, rdv[b]}, 8'h00);
  endtask
  task automatic eew(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_REG_OFS, a);
    wr(DATA_REG_OFS, d);
    wr(CTRL_REG_OFS, 8'h08);
    wr(CTRL_REG_OFS, 8'h0c);
  endtask
  task automatic t_reset;
    rd(BANK_REG_OFS);
    ck(rdv, BANK_RST);
    wr(CTRL_REG_OFS, 8'h0a);
    rd(CTRL_REG_OFS);
    ck(rdv, 8'h00);
    wr(BANK_REG_OFS, CTRL_BANK);
    rd(CTRL_REG_OFS);
    ck(rdv, {4'h0, CTRL_RST});
  endtask
  task automatic t_write;
    wr(CTRL_REG_OFS, 8'h04);
    rd(CTRL_REG_OFS);
    ck(rdv, 8'h00);
    wr(CTRL_REG_OFS, 8'h0c);
    rd(CTRL_REG_OFS);
    ck(rdv, 8'h08);
    eew(8'h2a, 8'ha5);
    rd(CORE_STAT_OFS);
    ck(rdv, 8'h02);
    wr(DATA_REG_OFS, 8'h11);
    wr(ADDR_REG_OFS, 8'h05);
    wt(CTRL_WR_POS);
    rd(MF_CTRL_OFS);
    ck(rdv & 8'h18, 8'h18);
    rd(CORE_STAT_OFS);
    ck(rdv, 8'h00);
    wr(CTRL_REG_OFS, 8'h00);
  endtask
  task automatic t_read;
    wr(ADDR_REG_OFS, 8'hea);
    rd(ADDR_REG_OFS);
    ck(rdv, 8'h2a);
    wr(CTRL_REG_OFS, 8'h01);
    rd(CTRL_REG_OFS);
    ck(rdv, 8'h00);
    wr(CTRL_REG_OFS, 8'h02);
    wr(CTRL_REG_OFS, 8'h03);
    wr(ADDR_REG_OFS, 8'h05);
    wt(CTRL_RD_POS);
    rd(DATA_REG_OFS);
    ck(rdv, 8'ha5);
    repeat (20) @(posedge core_clk);
    rd(DATA_REG_OFS);
    ck(rdv, 8'ha5);
    wr(INDIR_PTR_OFS, CTRL_INDIR_ADDR);
    rd(INDIR_PORT_OFS);
    ck(rdv, 8'h02);
    wr(INDIR_PORT_OFS, 8'h00);
    rd(CTRL_REG_OFS);
    ck(rdv, 8'h00);
  endtask
  task automatic t_irq;
    rd(IRQ_STAT_OFS);
    ck(rdv, 8'h03);
    wr(IRQ_STAT_OFS, 8'h03);
    rd(IRQ_STAT_OFS);
    ck(rdv, 8'h00);
    wr(MF_CTRL_OFS, 8'h07);
    wr(IRQ_MASK_OFS, 8'h02);
    fullCmd <= 1'b1;
    eew(8'h2b, 8'h3c);
    wt(CTRL_WR_POS);
    ck({7'h0, irq}, 8'h01);
    ck({7'h0, intVectorReq}, 8'h00);
    rd(MF_CTRL_OFS);
    ck(rdv, 8'h1f);
    @(posedge core_clk);
    fullCmd <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    ck({7'h0, intVectorReq}, 8'h01);
    repeat (12) @(posedge core_clk);
    rd(MF_CTRL_OFS);
    ck(rdv, 8'h17);
    ck({7'h0, intVectorReq}, 8'h00);
    wr(MF_CTRL_OFS, 8'h07);
    rd(MF_CTRL_OFS);
    ck(rdv, 8'h07);
    wr(IRQ_MASK_OFS, 8'h00);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    ck({7'h0, irq}, 8'h00);
    wr(IRQ_MASK_OFS, 8'h02);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    ck({7'h0, irq}, 8'h01);
    wr(IRQ_STAT_OFS, 8'h02);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    ck({7'h0, irq}, 8'h00);
    wr(CTRL_REG_OFS, 8'h00);
    wr(BANK_REG_OFS, 8'h00);
  endtask
  task automatic results;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_write();
    t_read();
    t_irq();
    results();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
